// ==== verilog/crg_regs.svh ====
// How it works
// - enable set: one cpu cycle in N
// - ratio 001 gives one in four
// - peripherals keep full clock while cpu idles
// - oscillators and bandgap stay on in slow mode
// - flash fetches next instruction before active cycle
// - four-phase peripheral clocks never stop
// - disable bit one turns its peripheral off
//
// Purpose: constants for cpu rate and module gating block
// Assumes: avalon byte offsets, 8-bit data in low lane
// Notes:   offsets below are byte addresses
`ifndef CRG_REGS_SVH
`define CRG_REGS_SVH
`define CRG_ADDR_W       4
`define CRG_OFF_RATE     4'h0
`define CRG_OFF_PDIS     4'h4
`define CRG_RATE_EN_BIT  7
`define CRG_RATE_MASK    8'h87
`define CRG_PDIS_MASK    8'hf1
`define CRG_RESET_BYTE   8'h00
`define CRG_PHASES       4
`define CRG_CNT_W        8
`define CRG_RATIO_001    3'h1
`define CRG_ZERO_CNT     8'h00
`endif

// ==== verilog/crg_pkg.sv ====
// Purpose: shared types for cpu rate and gating block
// Assumes: nothing
// Notes:   phase numbering follows q1..q4
package crg_pkg;
    typedef enum logic [1:0] {
        CRG_Q1,
        CRG_Q2,
        CRG_Q3,
        CRG_Q4
    } crg_phase_t;
endpackage : crg_pkg

// ==== verilog/crg_phase_gen.sv ====
// Purpose: free-running four-phase peripheral clock enables
// Assumes: one system clock, sync reset
// Notes:   no gate input at all, so slow mode cannot stop it
`timescale 1ns/1ns
`default_nettype none
`include "crg_regs.svh"
module crg_phase_gen (
    input  wire logic       clk,
    input  wire logic       resetn,
    output logic [3:0]      phase_q,
    output logic            cycle_end
);
    crg_pkg::crg_phase_t st_q;

    always_ff @(posedge clk)
    begin
        if (!resetn)
        begin
            st_q <= crg_pkg::CRG_Q1;
        end
        else
        begin
            case (st_q)
                crg_pkg::CRG_Q1: st_q <= crg_pkg::CRG_Q2;
                crg_pkg::CRG_Q2: st_q <= crg_pkg::CRG_Q3;
                crg_pkg::CRG_Q3: st_q <= crg_pkg::CRG_Q4;
                crg_pkg::CRG_Q4: st_q <= crg_pkg::CRG_Q1;
                default:         st_q <= crg_pkg::CRG_Q1;
            endcase
        end
    end

    always_ff @(posedge clk)
    begin
        if (!resetn)
        begin
            phase_q <= 4'h1;
        end
        else
        begin
            phase_q <= {phase_q[2:0], phase_q[3]};
        end
    end

    assign cycle_end = (st_q == crg_pkg::CRG_Q4);

    a_phase_onehot: assert property (@(posedge clk) disable iff (!resetn)
        $onehot(phase_q))
        else $error("phase clocks not one-hot");
    a_phase_rotate: assert property (@(posedge clk) disable iff (!resetn)
        phase_q[0] |-> ##4 phase_q[0])
        else $error("phase clocks stalled");
endmodule : crg_phase_gen
`default_nettype wire

// ==== verilog/crg_top.sv ====
// Purpose: reduced-rate cpu execution and module disable control
// Assumes: avalon-mm slave, answers in one cycle after request
// Notes:   cpu_run is an enable for the core, not a gated clock
//
// Our own choices: the address map and the Avalon-MM slave port.
`timescale 1ns/1ns
`default_nettype none
`include "crg_regs.svh"
module crg_top (
    input  wire logic                   clk,
    input  wire logic                   resetn,
    input  wire logic [`CRG_ADDR_W-1:0] avs_address,
    input  wire logic                   avs_read,
    input  wire logic                   avs_write,
    input  wire logic [31:0]            avs_writedata,
    input  wire logic [3:0]             avs_byteenable,
    output logic [31:0]                 avs_readdata,
    output logic                        avs_waitrequest,
    output logic                        cpu_run,
    output logic                        flash_fetch,
    output logic [3:0]                  periph_phase,
    output logic                        periph_clk_en,
    output logic                        osc_enable,
    output logic                        bandgap_enable,
    output logic                        serial_port2_off,
    output logic                        serial_port1_off,
    output logic                        sync_serial2_off,
    output logic                        sync_serial1_off,
    output logic                        waveform_gen_off
);
    logic [7:0]            rate_q;
    logic [7:0]            pdis_q;
    logic                  ack_q;
    logic [`CRG_CNT_W-1:0] cnt_q;
    logic                  cyc_end;
    logic                  slow_execute_enable;
    logic [2:0]            ratio_sel;
    logic                  req;
    logic                  wr_lane0;

    // ratio table: 000 -> 1:2, 001 -> 1:4 ... 111 -> 1:256
    function automatic logic [`CRG_CNT_W-1:0] crg_period_m1(
        input logic [2:0] sel);
        logic [8:0] n;
        n = 9'h002 << sel;
        crg_period_m1 = n[7:0] - 8'h01;
    endfunction : crg_period_m1

    crg_phase_gen u_phase (
        .clk       (clk),
        .resetn    (resetn),
        .phase_q   (periph_phase),
        .cycle_end (cyc_end)
    );

    assign req      = (avs_read | avs_write) & ~ack_q;
    // a write lands only at the edge where waitrequest is low
    assign wr_lane0 = avs_write & ack_q & avs_byteenable[0];
    // one wait cycle keeps read data on a registered path
    assign avs_waitrequest = req;

    always_ff @(posedge clk)
    begin
        if (!resetn)
        begin
            ack_q <= 1'b0;
        end
        else
        begin
            ack_q <= req;
        end
    end

    always_ff @(posedge clk)
    begin
        if (!resetn)
        begin
            rate_q <= `CRG_RESET_BYTE;
        end
        else if (wr_lane0 && avs_address == `CRG_OFF_RATE)
        begin
            rate_q <= avs_writedata[7:0] & `CRG_RATE_MASK;
        end
    end

    always_ff @(posedge clk)
    begin
        if (!resetn)
        begin
            pdis_q <= `CRG_RESET_BYTE;
        end
        else if (wr_lane0 && avs_address == `CRG_OFF_PDIS)
        begin
            pdis_q <= avs_writedata[7:0] & `CRG_PDIS_MASK;
        end
    end

    always_ff @(posedge clk)
    begin
        if (!resetn)
        begin
            avs_readdata <= 32'h0000_0000;
        end
        else if (avs_read && !ack_q)
        begin
            case (avs_address)
                `CRG_OFF_RATE: avs_readdata <= {24'h000000, rate_q};
                `CRG_OFF_PDIS: avs_readdata <= {24'h000000, pdis_q};
                default:       avs_readdata <= 32'h0000_0000;
            endcase
        end
    end

    assign slow_execute_enable = rate_q[`CRG_RATE_EN_BIT];
    assign ratio_sel           = rate_q[2:0];

    // counts instruction cycles; zero marks the active one
    always_ff @(posedge clk)
    begin
        if (!resetn)
        begin
            cnt_q <= `CRG_ZERO_CNT;
        end
        else if (!slow_execute_enable)
        begin
            cnt_q <= `CRG_ZERO_CNT;
        end
        else if (cyc_end)
        begin
            if (cnt_q >= crg_period_m1(ratio_sel))
            begin
                cnt_q <= `CRG_ZERO_CNT;
            end
            else
            begin
                cnt_q <= cnt_q + 8'h01;
            end
        end
    end

    assign cpu_run = !slow_execute_enable || (cnt_q == `CRG_ZERO_CNT);
    // fetch during the cycle before the next active one
    assign flash_fetch = !slow_execute_enable ||
        (cnt_q == crg_period_m1(ratio_sel));
    assign periph_clk_en  = 1'b1;
    assign osc_enable     = 1'b1;
    assign bandgap_enable = 1'b1;

    assign serial_port2_off = pdis_q[7];
    assign serial_port1_off = pdis_q[6];
    assign sync_serial2_off = pdis_q[5];
    assign sync_serial1_off = pdis_q[4];
    assign waveform_gen_off = pdis_q[0];

    a_ratio_four: assert property (@(posedge clk) disable iff (!resetn)
        (slow_execute_enable && ratio_sel == `CRG_RATIO_001 && cyc_end &&
         cpu_run && $stable(rate_q)) |-> ##1 !cpu_run [*8])
        else $error("1:4 idle span too short");
    a_run_normal: assert property (@(posedge clk) disable iff (!resetn)
        !slow_execute_enable |-> cpu_run && flash_fetch)
        else $error("cpu throttled while slow mode off");
    a_fetch_before: assert property (@(posedge clk) disable iff (!resetn)
        (slow_execute_enable && flash_fetch && cyc_end && $stable(rate_q))
        |=> cpu_run)
        else $error("fetch not followed by active cycle");
    a_osc_alive: assert property (@(posedge clk) disable iff (!resetn)
        osc_enable && bandgap_enable && periph_clk_en)
        else $error("oscillator or peripheral clock stopped");
    a_pdis_zero: assert property (@(posedge clk) disable iff (!resetn)
        pdis_q[3:1] == 3'h0)
        else $error("reserved disable bits set");
    a_disable_map: assert property (@(posedge clk) disable iff (!resetn)
        (wr_lane0 && avs_address == `CRG_OFF_PDIS) |=>
        serial_port2_off == $past(avs_writedata[7]) &&
        waveform_gen_off == $past(avs_writedata[0]))
        else $error("disable bit not applied");
    a_ack_one: assert property (@(posedge clk) disable iff (!resetn)
        req |=> !avs_waitrequest)
        else $error("bus answer late");
    a_reset_zero: assert property (@(posedge clk)
        !resetn |=> pdis_q == 8'h00)
        else $error("disable register not reset");
endmodule : crg_top
`default_nettype wire

// ==== verification/crg_bench.sv ====
// Purpose: self-checking bench for crg_top
// Assumes: answer one cycle after request, 4 clocks per instruction cycle
// Notes:   reads are checked by a watcher process off a queue
`timescale 1ns/1ns
`default_nettype none
module cpu_rate_and_module_gating_bench;
    logic        clk = 0;
    logic        resetn = 0;
    logic [3:0]  adr = 0;
    logic        rd = 0;
    logic        wr = 0;
    logic [31:0] wd = 0;
    logic [3:0]  be = 0;
    logic [31:0] rdat;
    logic        waitreq;
    logic        run;
    logic        fetch;
    logic        pce;
    logic        osc;
    logic        bg;
    logic [3:0]  ph;
    logic [4:0]  off;
    logic [31:0] exp_q[$];
    logic [7:0]  pd;
    int          failures = 0;
    int          comparisons = 0;
    int          seed = 32'he5fc;
    int          n_run;
    int          n_ftc;
    int          n_q1;
    int          n_on;

    crg_top crg_top_inst (.clk(clk), .resetn(resetn), .avs_address(adr),
        .avs_read(rd), .avs_write(wr), .avs_writedata(wd),
        .avs_byteenable(be), .avs_readdata(rdat), .avs_waitrequest(waitreq),
        .cpu_run(run), .flash_fetch(fetch), .periph_phase(ph),
        .periph_clk_en(pce), .osc_enable(osc), .bandgap_enable(bg),
        .serial_port2_off(off[4]), .serial_port1_off(off[3]),
        .sync_serial2_off(off[2]), .sync_serial1_off(off[1]),
        .waveform_gen_off(off[0]));

    initial
    begin
        forever #10 clk = ~clk;
    end

    task give_verdict;
        $display("failures %0d comparisons %0d", failures, comparisons);
        if (failures == 0 && comparisons > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : give_verdict

    task check(input logic [31:0] seen, input logic [31:0] want,
               input string what);
        comparisons++;
        if (seen !== want)
        begin
            failures++;
            $display("Error %s expected %h seen %h", what, want, seen);
        end
    endtask : check

    // read notes its expectation; held until waitrequest is seen low
    task bus(input logic w, input logic [3:0] a, input logic [7:0] d,
             input logic [3:0] b, input logic [7:0] e);
        int i;
        if (!w)
            exp_q.push_back({24'h0, e});
        @(posedge clk);
        adr <= a;
        wd <= {24'h0, d};
        be <= b;
        rd <= !w;
        wr <= w;
        i = 0;
        do
        begin
            @(negedge clk);
            i++;
        end
        while (waitreq !== 1'b0 && i < 20);
        if (i >= 20)
        begin
            failures++;
            give_verdict;
        end
        else
        begin
            @(posedge clk);
            rd <= 0;
            wr <= 0;
        end
    endtask : bus

    task measure(input int cyc);
        n_run = 0;
        n_ftc = 0;
        n_q1 = 0;
        n_on = 0;
        repeat (cyc)
        begin
            @(negedge clk);
            n_run += (run === 1'b1);
            n_ftc += (fetch === 1'b1);
            n_q1 += (ph === 4'h1);
            n_on += ({pce, osc, bg} === 3'h7);
        end
    endtask : measure

    always @(negedge clk)
    begin
        if (rd && waitreq === 1'b0)
        begin
            if (exp_q.size() == 0)
                check(rdat, 32'hdead, "unexpected read");
            else
                check(rdat, exp_q.pop_front(), "readdata");
        end
    end

    initial
    begin
        repeat (3) @(posedge clk);
        resetn <= 1;
        bus(0, 4'h0, 8'h00, 4'hf, 8'h00);
        bus(0, 4'h4, 8'h00, 4'hf, 8'h00);
        bus(0, 4'h8, 8'h00, 4'hf, 8'h00);
        repeat (4)
        begin
            pd = $random(seed);
            bus(1, 4'h4, pd, 4'hf, 8'h00);
            // no lane 0 enable, so this write must not land
            bus(1, 4'h4, ~pd, 4'he, 8'h00);
            bus(0, 4'h4, 8'h00, 4'hf, pd & 8'hf1);
            check(off, {pd[7:4], pd[0]}, "disable outputs");
        end
        measure(64);
        check(n_run, 64, "run normal");
        check(n_ftc, 64, "fetch normal");
        for (int n = 0; n < 8; n++)
        begin
            bus(1, 4'h0, 8'h80 | 8'(n), 4'hf, 8'h00);
            bus(0, 4'h0, 8'h00, 4'hf, 8'h80 | 8'(n));
            // one full period lets the ratio counter settle
            repeat (4 << (n + 1)) @(posedge clk);
            measure(8 << (n + 1));
            check(n_run, 8, "run count");
            check(n_q1, 2 << (n + 1), "q1 count");
            check(n_on, 8 << (n + 1), "clocks on");
            check(n_ftc, 8, "fetch count");
        end
        bus(1, 4'h0, 8'h00, 4'hf, 8'h00);
        measure(16);
        check(n_run, 16, "run after slow");
        resetn <= 0;
        repeat (3) @(posedge clk);
        resetn <= 1;
        bus(0, 4'h4, 8'h00, 4'hf, 8'h00);
        bus(0, 4'h0, 8'h00, 4'hf, 8'h00);
        measure(16);
        check(n_run, 16, "run after reset");
        give_verdict;
    end
endmodule : cpu_rate_and_module_gating_bench
`default_nettype wire
